// ===== tssc_core.sv
// Scratchpad, nonvolatile image, conversion timing, alarm and CRC of the sensor
`timescale 1ns/1ps
`include "tssc_map.svh"

// Overview of operation
// - Alarm compare uses temperature bits 11..4 against each limit, both signed.
// - Alarm set when temperature at or below low limit, or at or above high.
// - Alarm flag recomputed at every conversion end, cleared when back in range.
// - Alarm search joins only with alarm flag set, silent otherwise.
// - Limits are signed bytes, sign in bit 7, kept in nonvolatile storage.
// - Supply query answers 0 when parasite powered, 1 when externally supplied.
// - Identity code is family byte, 48-bit serial, then CRC of low 56 bits.
// - Bytes 0 and 1 show temperature low and high, never written.
// - Byte 5 reserved and unwritable; bytes 6 and 7 are user storage.
// - Byte 8 is read-only CRC over bytes 0..7, refreshed on change.
// - Scratchpad write loads bytes 2,3,4,6,7 in order, LSB first.
// - Scratchpad read shifts from byte 0 LSB upward.
// - Copy stores high limit, low limit and config in nonvolatile storage.
// - Power-up reloads all nonvolatile bytes before serving commands.
// - Recall reloads scratchpad; slots read 0 while busy, 1 when done.
// - Config bits 6..5 writable, reset 11; bit 7 reads 0, bits 4..0 read 1.
// - Resolution codes 00..11 give 9..12 bits, 93.75..750 ms conversions.
// - CRC polynomial x^8+x^5+x^4+1, starts at zero, LSB first.
// - CRC mismatches never block or abort a command sequence.
// - Temperature is 16-bit signed, 1/16 degree LSB, low bits undefined below 12.
// - Temperature reads 0550h from power-on until first conversion ends.
// - Externally supplied, slots after convert read 0 while busy, 1 when done.
module tssc_core
  import tssc_pkg::*;
#(
  parameter logic [31:0] CONV_CYCLES = 32'(`TSSC_CONV_CYC),
  parameter logic [31:0] TWR_CYCLES  = 32'(`TSSC_TWR_CYC),
  parameter logic [7:0]  FAMILY_CODE = 8'h5a,          // Arbitrary value
  parameter logic [47:0] SERIAL_NUM  = 48'h0123456789ab // Arbitrary value
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        bus_reset_i,
  input  wire logic        wr_valid_i,
  input  wire logic [7:0]  wr_byte_i,
  output logic             wr_ready_o,
  input  wire logic        rd_slot_i,
  output logic             rd_valid_o,
  output logic             rd_bit_o,
  input  wire logic        parasite_pin_i,
  input  wire logic [15:0] temp_sample_i,
  output logic             conv_busy_o,
  output logic             nv_busy_o,
  output logic             alarm_flag_o,
  output logic             search_join_o,
  output logic [63:0]      rom_code_o
);

  // Reflected CRC-8, bits enter LSB first, register starts at zero
  function automatic logic [7:0] crc8_bits(input logic [63:0] data, input int nbits);
    logic [7:0] crc;
    logic       fb;
    crc = 8'h00;
    for (int i = 0; i < 64; i++)
    begin
      if (i < nbits)
      begin
        fb  = crc[0] ^ data[i];
        crc = {1'b0, crc[7:1]};
        if (fb)
          crc = crc ^ `TSSC_CRC_POLY_REFL;
      end
    end
    return crc;
  endfunction : crc8_bits

  // Config byte with only the resolution field taken from the value
  function automatic logic [7:0] cfg_clean(input logic [7:0] value);
    return {1'b0, value[`TSSC_CFG_RES_HI:`TSSC_CFG_RES_LO], `TSSC_CFG_FIXED};
  endfunction : cfg_clean

  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  wire  rst_n = rst_s2_q;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Supply pin: three stages, change taken once stages two and three agree
  logic par_s1_q;
  logic par_s2_q;
  logic par_s3_q;
  logic parasite_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_s1_q   <= 1'b0;
      par_s2_q   <= 1'b0;
      par_s3_q   <= 1'b0;
      parasite_q <= 1'b0;
    end
    else
    begin
      par_s1_q <= parasite_pin_i;
      par_s2_q <= par_s1_q;
      par_s3_q <= par_s2_q;
      if (par_s2_q == par_s3_q)
        parasite_q <= par_s3_q;
    end
  end

  // Incoming bytes pass through a small FIFO
  logic       fifo_valid;
  logic [7:0] fifo_byte;
  logic       fifo_pop;

  tssc_fifo #(
    .WIDTH (8),
    .DEPTH (`TSSC_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n),
    .flush_i     (bus_reset_i),
    .in_valid_i  (wr_valid_i),
    .in_data_i   (wr_byte_i),
    .in_ready_o  (wr_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_byte),
    .out_ready_i (fifo_pop)
  );

  tssc_state_type    state_q;
  tssc_nv_image_type nv_q;
  tssc_nv_image_type spad_q;
  logic [15:0]       temp_q;
  logic [7:0]        spad_crc_q;
  logic [2:0]        wr_idx_q;
  logic [6:0]        rd_idx_q;
  logic [3:0]        recall_cnt_q;
  logic              recall_busy_q;
  logic [31:0]       conv_cnt_q;
  logic              conv_busy_q;
  logic [1:0]        conv_res_q;
  logic [31:0]       twr_cnt_q;
  logic              twr_busy_q;
  logic              alarm_q;
  tssc_slot_answer_type answer_q;
  tssc_slot_answer_type answer_d;

  // Scratchpad image as sent on a read, byte 0 in the low bits
  wire [63:0] spad_body = {spad_q.user_b, spad_q.user_a, `TSSC_RSVD_BYTE,
                           spad_q.config_byte, spad_q.lower_limit,
                           spad_q.upper_limit, temp_q};
  wire [71:0] spad_bits = {spad_crc_q, spad_body};

  wire        loading  = (state_q == ST_RELOAD) || recall_busy_q;
  assign fifo_pop      = fifo_valid && !loading && !bus_reset_i;
  wire        take     = fifo_pop;
  wire        cmd_take = take && (state_q == ST_CMD);
  wire        wr_take  = take && (state_q == ST_WRITE);

  // Conversion length scaled by resolution
  wire [1:0]  res_now   = spad_q.config_byte[`TSSC_CFG_RES_HI:`TSSC_CFG_RES_LO];
  wire [31:0] conv_len  = CONV_CYCLES >> (2'h3 - res_now);
  wire        conv_end  = conv_busy_q && (conv_cnt_q == 32'h1);
  wire        twr_end   = twr_busy_q && (twr_cnt_q == 32'h1);

  // Result with undefined fraction bits cleared at lower resolution
  wire [15:0] res_mask  = 16'hffff << (2'h3 - conv_res_q);
  wire [15:0] new_temp  = temp_sample_i & res_mask;

  // Alarm compare on whole degrees only
  wire signed [7:0] cmp_temp  = signed'(new_temp[11:4]);
  wire signed [7:0] cmp_upper = signed'(spad_q.upper_limit);
  wire signed [7:0] cmp_lower = signed'(spad_q.lower_limit);
  wire        alarm_now = (cmp_temp <= cmp_lower) || (cmp_temp >= cmp_upper);

  // Command dispatch, bus reset returns to waiting for a command
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= ST_RELOAD;
    else if (state_q == ST_RELOAD)
    begin
      if (recall_cnt_q == 4'h1)
        state_q <= ST_CMD;
    end
    else if (bus_reset_i)
      state_q <= ST_CMD;
    else if (cmd_take)
    begin
      case (fifo_byte)
        `TSSC_CMD_CONVERT:    state_q <= ST_POLL_CONV;
        `TSSC_CMD_WRITE:      state_q <= ST_WRITE;
        `TSSC_CMD_READ:       state_q <= ST_READ;
        `TSSC_CMD_COPY:       state_q <= ST_POLL_COPY;
        `TSSC_CMD_RECALL:     state_q <= ST_POLL_RECALL;
        `TSSC_CMD_SUPPLY:     state_q <= ST_SUPPLY;
        `TSSC_CMD_ALARM_SRCH: state_q <= ST_SEARCH;
        default:              state_q <= ST_IGNORE;
      endcase
    end
    else if (wr_take && (wr_idx_q == `TSSC_WRITE_BYTES - 3'h1))
      state_q <= ST_IGNORE;
  end

  // Write pointer and read bit index
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_idx_q <= 3'h0;
      rd_idx_q <= 7'h00;
    end
    else if (cmd_take || bus_reset_i)
    begin
      wr_idx_q <= 3'h0;
      rd_idx_q <= 7'h00;
    end
    else
    begin
      if (wr_take)
        wr_idx_q <= wr_idx_q + 3'h1;
      if (rd_slot_i && (state_q == ST_READ) && (rd_idx_q != `TSSC_SPAD_BITS))
        rd_idx_q <= rd_idx_q + 7'h01;
    end
  end

  // Reload timer, shared by power-up and recall
  wire recall_start = cmd_take && (fifo_byte == `TSSC_CMD_RECALL);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      recall_cnt_q  <= `TSSC_RECALL_CYC;
      recall_busy_q <= 1'b0;
    end
    else if (recall_start)
    begin
      recall_cnt_q  <= `TSSC_RECALL_CYC;
      recall_busy_q <= 1'b1;
    end
    else if (recall_cnt_q != 4'h0 && (recall_busy_q || state_q == ST_RELOAD))
    begin
      recall_cnt_q <= recall_cnt_q - 4'h1;
      if (recall_cnt_q == 4'h1)
        recall_busy_q <= 1'b0;
    end
  end

  wire reload_done = (recall_cnt_q == 4'h1) && (recall_busy_q || state_q == ST_RELOAD);

  // Scratchpad writable bytes
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spad_q.upper_limit <= 8'h00;
      spad_q.lower_limit <= 8'h00;
      spad_q.config_byte <= `TSSC_CFG_RESET;
      spad_q.user_a      <= 8'h00;
      spad_q.user_b      <= 8'h00;
    end
    else if (reload_done)
    begin
      spad_q <= nv_q;
    end
    else if (wr_take)
    begin
      // Temperature and reserved byte are not in the write order
      case (wr_idx_q)
        3'h0:    spad_q.upper_limit <= fifo_byte;
        3'h1:    spad_q.lower_limit <= fifo_byte;
        3'h2:    spad_q.config_byte <= cfg_clean(fifo_byte);
        3'h3:    spad_q.user_a      <= fifo_byte;
        default: spad_q.user_b      <= fifo_byte;
      endcase
    end
  end

  // Nonvolatile image and its write time
  wire copy_start = cmd_take && (fifo_byte == `TSSC_CMD_COPY);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nv_q.upper_limit <= `TSSC_NV_UPPER_INIT;
      nv_q.lower_limit <= `TSSC_NV_LOWER_INIT;
      nv_q.config_byte <= `TSSC_CFG_RESET;
      nv_q.user_a      <= `TSSC_NV_USER_INIT;
      nv_q.user_b      <= `TSSC_NV_USER_INIT;
      twr_cnt_q        <= 32'h0;
      twr_busy_q       <= 1'b0;
    end
    else if (copy_start)
    begin
      nv_q.upper_limit <= spad_q.upper_limit;
      nv_q.lower_limit <= spad_q.lower_limit;
      nv_q.config_byte <= spad_q.config_byte;
      twr_cnt_q        <= TWR_CYCLES;
      twr_busy_q       <= 1'b1;
    end
    else if (twr_busy_q)
    begin
      twr_cnt_q <= twr_cnt_q - 32'h1;
      if (twr_end)
        twr_busy_q <= 1'b0;
    end
  end

  // Conversion timer, result capture and alarm evaluation
  wire conv_start = cmd_take && (fifo_byte == `TSSC_CMD_CONVERT) && !conv_busy_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_cnt_q  <= 32'h0;
      conv_busy_q <= 1'b0;
      conv_res_q  <= `TSSC_RES_RESET;
      temp_q      <= `TSSC_TEMP_RESET;
      alarm_q     <= 1'b0;
    end
    else if (conv_start)
    begin
      conv_cnt_q  <= conv_len;
      conv_busy_q <= 1'b1;
      conv_res_q  <= res_now;
    end
    else if (conv_busy_q)
    begin
      conv_cnt_q <= conv_cnt_q - 32'h1;
      if (conv_end)
      begin
        conv_busy_q <= 1'b0;
        temp_q      <= new_temp;
        alarm_q     <= alarm_now;
      end
    end
  end

  // CRC of bytes 0..7 refreshed every cycle
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      spad_crc_q <= 8'h00;
    else
      spad_crc_q <= crc8_bits(spad_body, `TSSC_SPAD_CRC_BITS);
  end

  // Read slot answers by mode; 1 means line released
  always_comb
  begin
    answer_d.valid = rd_slot_i;
    answer_d.level = 1'b1;
    case (state_q)
      ST_READ:
        if (rd_idx_q != `TSSC_SPAD_BITS)
          answer_d.level = spad_bits[rd_idx_q];
      ST_POLL_CONV:   answer_d.level = !conv_busy_q;
      ST_POLL_COPY:   answer_d.level = !twr_busy_q;
      ST_POLL_RECALL: answer_d.level = !recall_busy_q;
      ST_SUPPLY:      answer_d.level = !parasite_q;
      default:        answer_d.level = 1'b1;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      answer_q      <= '{valid: 1'b0, level: 1'b1};
      search_join_o <= 1'b0;
      alarm_flag_o  <= 1'b0;
      conv_busy_o   <= 1'b0;
      nv_busy_o     <= 1'b0;
      rom_code_o    <= 64'h0;
    end
    else
    begin
      answer_q      <= answer_d;
      search_join_o <= (state_q == ST_SEARCH) && alarm_q;
      alarm_flag_o  <= alarm_q;
      conv_busy_o   <= conv_busy_q;
      nv_busy_o     <= twr_busy_q;
      rom_code_o    <= {crc8_bits({8'h00, SERIAL_NUM, FAMILY_CODE}, `TSSC_ROM_CRC_BITS),
                        SERIAL_NUM, FAMILY_CODE};
    end
  end

  assign rd_valid_o = answer_q.valid;
  assign rd_bit_o   = answer_q.level;

endmodule : tssc_core

// ===== tssc_map.svh
// Offsets, reset values, command codes and timing counts for the sensor core
`ifndef TSSC_MAP_SVH
`define TSSC_MAP_SVH

`define TSSC_OFS_TEMP_LO    4'h0
`define TSSC_OFS_TEMP_HI    4'h1
`define TSSC_OFS_UPPER      4'h2
`define TSSC_OFS_LOWER      4'h3
`define TSSC_OFS_CONFIG     4'h4
`define TSSC_OFS_RSVD       4'h5
`define TSSC_OFS_USER_A     4'h6
`define TSSC_OFS_USER_B     4'h7
`define TSSC_OFS_CRC        4'h8

`define TSSC_TEMP_RESET     16'h0550
`define TSSC_CFG_RES_HI     6
`define TSSC_CFG_RES_LO     5
`define TSSC_CFG_FIXED      5'h1f
`define TSSC_CFG_RESET      8'h7f
`define TSSC_RES_RESET      2'h3
`define TSSC_RSVD_BYTE      8'hff
`define TSSC_NV_UPPER_INIT  8'h4b
`define TSSC_NV_LOWER_INIT  8'h46
`define TSSC_NV_USER_INIT   8'hff

`define TSSC_CMD_CONVERT    8'h44
`define TSSC_CMD_WRITE      8'h4e
`define TSSC_CMD_READ       8'hbe
`define TSSC_CMD_COPY       8'h48
`define TSSC_CMD_RECALL     8'hb8
`define TSSC_CMD_SUPPLY     8'hb4
`define TSSC_CMD_ALARM_SRCH 8'hec

`define TSSC_CRC_POLY_REFL  8'h8c
`define TSSC_WRITE_BYTES    3'h5
`define TSSC_SPAD_BITS      7'h48
`define TSSC_ROM_CRC_BITS   56
`define TSSC_SPAD_CRC_BITS  64

`define TSSC_CLK_MHZ        250
`define TSSC_CONVERSION_TIME_US       750000
`define TSSC_TWR_US         10000
`define TSSC_CONV_CYC       (`TSSC_CONVERSION_TIME_US * `TSSC_CLK_MHZ)
`define TSSC_TWR_CYC        (`TSSC_TWR_US * `TSSC_CLK_MHZ)
`define TSSC_RECALL_CYC     4'h8
`define TSSC_FIFO_DEPTH     4

`endif

// ===== tssc_pkg.sv
// Types used by the sensor core; its input buffer does not import them
package tssc_pkg;

  typedef enum logic [3:0] {
    ST_RELOAD,
    ST_CMD,
    ST_WRITE,
    ST_READ,
    ST_POLL_CONV,
    ST_POLL_COPY,
    ST_POLL_RECALL,
    ST_SUPPLY,
    ST_SEARCH,
    ST_IGNORE
  } tssc_state_type;

  // Bytes backed by nonvolatile storage, in scratchpad order
  typedef struct packed {
    logic [7:0] user_b;
    logic [7:0] user_a;
    logic [7:0] config_byte;
    logic [7:0] lower_limit;
    logic [7:0] upper_limit;
  } tssc_nv_image_type;

  // Answer to one read slot
  typedef struct packed {
    logic valid;
    logic level;
  } tssc_slot_answer_type;

endpackage : tssc_pkg

// ===== tssc_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tssc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             room_q;
  wire              push = in_valid_i && room_q;
  wire              pop  = out_ready_i && (count_q != '0);

  assign count_d     = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o  = room_q;
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      room_q   <= 1'b1;
    end
    else if (flush_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      room_q   <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_d;
      room_q  <= (count_d != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end

endmodule : tssc_fifo

// ===== tssc_core_asserts.sv
// Port-level checks on the sensor core
`timescale 1ns/1ps
module tssc_core_asserts #(
  parameter logic [31:0] CONV_CYCLES = 32'd800,
  parameter logic [31:0] TWR_CYCLES  = 32'd100
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rd_slot_i,
  input  wire logic        rd_valid_o,
  input  wire logic        conv_busy_o,
  input  wire logic        nv_busy_o,
  input  wire logic        alarm_flag_o,
  input  wire logic        search_join_o,
  input  wire logic [63:0] rom_code_o
);
  localparam int CONV_LO = CONV_CYCLES / 8 - 2;
  localparam int CONV_HI = CONV_CYCLES + 2;
  localparam int TWR_LO  = TWR_CYCLES - 2;
  localparam int TWR_HI  = TWR_CYCLES + 2;
  logic seen_q;
  logic seen_d;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic [7:0] crc56(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ (((c[0] ^ d[i]) == 1'b1) ? 8'h8c : 8'h00);
    return c;
  endfunction : crc56

  // A conversion has been started since reset
  assign seen_d = seen_q | conv_busy_o;
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      seen_q <= 1'b0;
    else
      seen_q <= seen_d;

  rd_answer_a: assert property (rd_slot_i |=> rd_valid_o)
    else $error("read slot got no answer");
  rd_cause_a: assert property (rd_valid_o |-> $past(rd_slot_i))
    else $error("answer without read slot");
  rom_crc_a: assert property (rom_code_o != 64'h0 |->
    rom_code_o[63:56] == crc56(rom_code_o[55:0])) else $error("identity crc wrong");
  alarm_end_a: assert property ($changed(alarm_flag_o) |->
    conv_busy_o || $past(conv_busy_o)) else $error("alarm moved outside conversion end");
  search_alarm_a: assert property (search_join_o |-> alarm_flag_o)
    else $error("search joined without alarm");
  nv_time_a: assert property ($rose(nv_busy_o) |-> ##[TWR_LO:TWR_HI] $fell(nv_busy_o))
    else $error("nonvolatile write time wrong");
  conv_time_a: assert property ($rose(conv_busy_o) |->
    ##[CONV_LO:CONV_HI] $fell(conv_busy_o)) else $error("conversion time wrong");
  alarm_start_a: assert property (!seen_q |-> !alarm_flag_o)
    else $error("alarm before first conversion");
endmodule : tssc_core_asserts

bind tssc_core tssc_core_asserts #(.CONV_CYCLES(CONV_CYCLES), .TWR_CYCLES(TWR_CYCLES))
  i_tssc_core_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rd_slot_i(rd_slot_i),
  .rd_valid_o(rd_valid_o), .conv_busy_o(conv_busy_o), .nv_busy_o(nv_busy_o),
  .alarm_flag_o(alarm_flag_o), .search_join_o(search_join_o), .rom_code_o(rom_code_o));

// ===== tssc_master_model.sv
// Bus master stand-in: byte writes, read slots and crc check
`timescale 1ns/1ps
`include "tssc_map.svh"
module tssc_master_model (
  input  wire logic       mclk_i,
  input  wire logic       wr_ready_i,
  input  wire logic       rd_valid_i,
  input  wire logic       rd_bit_i,
  output logic            bus_reset_o,
  output logic            wr_valid_o,
  output logic      [7:0] wr_byte_o,
  output logic            rd_slot_o
);
  initial
  begin
    bus_reset_o = 1'b0;
    wr_valid_o = 1'b0;
    wr_byte_o = 8'h00;
    rd_slot_o = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b);
    @(negedge mclk_i);
    wr_valid_o = 1'b1;
    wr_byte_o = b;
    while (wr_ready_i !== 1'b1)
      @(negedge mclk_i);
    @(negedge mclk_i);
    wr_valid_o = 1'b0;
    // Released data shows no stale byte
    wr_byte_o = ~b;
  endtask : send_byte

  task automatic start_cmd(input logic [7:0] cmd);
    @(negedge mclk_i);
    bus_reset_o = 1'b1;
    @(negedge mclk_i);
    bus_reset_o = 1'b0;
    send_byte(cmd);
  endtask : start_cmd

  task automatic read_bit(output logic b);
    @(negedge mclk_i);
    rd_slot_o = 1'b1;
    @(negedge mclk_i);
    rd_slot_o = 1'b0;
    // Answer stands only in the cycle after the slot
    b = (rd_valid_i === 1'b1) ? rd_bit_i : 1'bx;
  endtask : read_bit

  // Parasite supply: strong pullup held, no byte or slot meanwhile
  task automatic hold_pullup(input int cycles);
    repeat (cycles) @(negedge mclk_i);
  endtask : hold_pullup

  task automatic read_pad(output logic [71:0] pad, output logic crc_ok);
    logic [7:0] c;
    logic       b;
    c = 8'h00;
    start_cmd(`TSSC_CMD_READ);
    for (int i = 0; i < 72; i++)
    begin
      read_bit(b);
      pad[i] = b;
      c = (c >> 1) ^ (((c[0] ^ b) === 1'b1) ? 8'h8c : 8'h00);
    end
    crc_ok = (c === 8'h00);
  endtask : read_pad

  task automatic poll(output logic first, output logic done);
    read_bit(first);
    done = first;
    for (int i = 0; i < 400 && done !== 1'b1; i++)
      read_bit(done);
  endtask : poll
endmodule : tssc_master_model

// ===== tssc_core_tb.sv
// Self-checking bench for the sensor core
`timescale 1ns/1ps
`include "tssc_map.svh"
module tssc_core_tb;
  logic        mclk, rst_n, bus_reset, wr_valid, wr_ready, rd_slot, rd_valid, rd_bit;
  logic        parasite_pin, conv_busy, nv_busy, alarm_flag, search_join, first, done;
  logic [7:0]  wr_byte;
  logic [15:0] temp_sample;
  logic [63:0] rom_code;
  logic [15:0] temps [3] = '{16'h0191, 16'h0110, 16'hff61};
  logic        alarms [3] = '{1'b1, 1'b0, 1'b1};
  int          err_total;
  int          checked;

  tssc_core #(.CONV_CYCLES(32'd800), .TWR_CYCLES(32'd100),
    .FAMILY_CODE(8'h3c), .SERIAL_NUM(48'h0a0b0c0d0e0f)) // Arbitrary identity
  i_tssc_core (.mclk_i(mclk), .rst_n_i(rst_n), .bus_reset_i(bus_reset),
    .wr_valid_i(wr_valid), .wr_byte_i(wr_byte), .wr_ready_o(wr_ready),
    .rd_slot_i(rd_slot), .rd_valid_o(rd_valid), .rd_bit_o(rd_bit),
    .parasite_pin_i(parasite_pin), .temp_sample_i(temp_sample), .conv_busy_o(conv_busy),
    .nv_busy_o(nv_busy), .alarm_flag_o(alarm_flag), .search_join_o(search_join),
    .rom_code_o(rom_code));

  tssc_master_model i_tssc_master_model (.mclk_i(mclk), .wr_ready_i(wr_ready),
    .rd_valid_i(rd_valid), .rd_bit_i(rd_bit), .bus_reset_o(bus_reset),
    .wr_valid_o(wr_valid), .wr_byte_o(wr_byte), .rd_slot_o(rd_slot));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic check_pad(input logic [63:0] exp, input logic [63:0] m);
    logic [71:0] pad;
    logic        ok;
    i_tssc_master_model.read_pad(pad, ok);
    for (int k = 0; k < 8; k++)
      chk("scratchpad byte", 16'(exp[8*k +: 8] & m[8*k +: 8]),
          16'(pad[8*k +: 8] & m[8*k +: 8]));
    chk("scratchpad crc residue", 16'h0001, 16'(ok));
  endtask : check_pad

  task automatic write_pad(input logic [39:0] v);
    i_tssc_master_model.start_cmd(`TSSC_CMD_WRITE);
    for (int k = 0; k < 5; k++)
      i_tssc_master_model.send_byte(v[8*k +: 8]);
  endtask : write_pad

  task automatic close_out;
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    close_out();
  end

  initial
  begin
    err_total = 0;
    checked = 0;
    rst_n = 1'b0;
    parasite_pin = 1'b0;
    temp_sample = 16'h0000;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (12) @(negedge mclk);
    chk("family code", 16'h003c, 16'(rom_code[7:0]));
    chk("serial low", 16'h0e0f, rom_code[23:8]);
    check_pad(64'hffffff7f464b0550, '1);
    chk("alarm before conversion", 16'h0000, 16'(alarm_flag));
    write_pad(40'h341280f619);
    check_pad(64'h3412ff1ff6190550, '1);
    for (int k = 0; k < 3; k++)
    begin
      temp_sample = temps[k];
      i_tssc_master_model.start_cmd(`TSSC_CMD_CONVERT);
      i_tssc_master_model.poll(first, done);
      chk("convert busy slot", 16'h0000, 16'(first));
      chk("convert done slot", 16'h0001, 16'(done));
      chk("alarm flag", 16'(alarms[k]), 16'(alarm_flag));
      i_tssc_master_model.start_cmd(`TSSC_CMD_ALARM_SRCH);
      repeat (3) @(negedge mclk);
      chk("alarm search join", 16'(alarms[k]), 16'(search_join));
    end
    check_pad(64'h3412ff1ff619ff60, '1);
    i_tssc_master_model.start_cmd(`TSSC_CMD_COPY);
    repeat (3) @(negedge mclk);
    chk("copy busy", 16'h0001, 16'(nv_busy));
    i_tssc_master_model.poll(first, done);
    chk("copy done slot", 16'h0001, 16'(done));
    write_pad(40'h0000e00000);
    i_tssc_master_model.start_cmd(`TSSC_CMD_RECALL);
    i_tssc_master_model.poll(first, done);
    chk("recall busy slot", 16'h0000, 16'(first));
    chk("recall done slot", 16'h0001, 16'(done));
    check_pad(64'hffffff1ff619ff60, '1);
    parasite_pin = 1'b1;
    write_pad(40'h341280f67f);
    temp_sample = 16'h0110;
    i_tssc_master_model.start_cmd(`TSSC_CMD_CONVERT);
    i_tssc_master_model.hold_pullup(120);
    chk("conversion under pullup", 16'h0000, 16'(conv_busy));
    chk("alarm after new limits", 16'h0000, 16'(alarm_flag));
    i_tssc_master_model.start_cmd(`TSSC_CMD_SUPPLY);
    i_tssc_master_model.read_bit(first);
    chk("supply parasite", 16'h0000, 16'(first));
    parasite_pin = 1'b0;
    i_tssc_master_model.start_cmd(`TSSC_CMD_SUPPLY);
    i_tssc_master_model.read_bit(first);
    chk("supply external", 16'h0001, 16'(first));
    close_out();
  end
endmodule : tssc_core_tb
